// *** logic/fcw_pkg.sv ***
// package for the fieldbus command word decoder: bit positions, reset values
// assumes one clock domain and a synchronous active-high reset
package fcw_pkg;

	// ----------------------------------------
	// command word layout
	// ----------------------------------------
	localparam int             FCW_W          = 16;
	localparam int             PD_W           = 16;
	localparam int             BIT_SW_ON_EN   = 0;
	localparam int             BIT_MCB_EN     = 1;
	localparam int             BIT_QSTOP_N    = 2;
	localparam int             BIT_START      = 3;
	localparam int             BIT_PRECHARGE  = 4;
	localparam int             BIT_ACK        = 7;
	localparam int             BIT_VALID      = 10;
	localparam int             BIT_WDOG       = 11;
	localparam int             BIT_CUST_LO    = 12;
	localparam int             N_CUST         = 4;
	localparam logic [15:0]    FCW_DEFAULT    = 16'h0005;
	localparam logic [15:0]    PD_RESET       = 16'h0000;

	// ----------------------------------------
	// decoded commands
	// ----------------------------------------
	typedef struct packed {
		logic       run_enable;
		logic       quick_stop;
		logic       mcb_enable;
		logic       precharge;
		logic       start;
		logic [3:0] custom;
	} fcw_cmd_t;

endpackage

// *** logic/fcw_decoder.sv ***
// fieldbus command word decoder: qualifies, holds and decodes the command word
// assumes the word and process data arrive synchronous to i_clk_sys
module fcw_decoder
	import fcw_pkg::*;
#(
	parameter int N_CUSTOM = N_CUST
) (
	input  wire logic             i_clk_sys,
	input  wire logic             i_sys_rst,
	input  wire logic [FCW_W-1:0] i_cmd_word,
	input  wire logic [PD_W-1:0]  i_proc_data,
	input  wire logic             i_is_modbus,
	input  wire logic             i_place_fieldbus,
	input  wire logic             i_ack_place_indep,
	input  wire logic             i_wdog_fault,
	output logic [FCW_W-1:0]      o_eff_word,
	output logic [PD_W-1:0]       o_proc_data,
	output fcw_cmd_t              o_cmd,
	output logic                  o_ack_pulse,
	output logic                  o_wdog_in
);

	// ----------------------------------------
	// live taps
	// ----------------------------------------
	// the qualifier and the watchdog bit bypass every hold: they are read straight off the wire
	logic                valid;
	logic                wd_live;

	always_comb begin
		valid   = i_cmd_word[BIT_VALID];
		wd_live = i_cmd_word[BIT_WDOG];
	end

	// ----------------------------------------
	// held command word
	// ----------------------------------------
	// starts at the default word, so the default stands until a qualified word arrives
	logic [FCW_W-1:0]    held_q;
	logic [FCW_W-1:0]    held_d;

	always_comb begin
		held_d = valid ? i_cmd_word : held_q;
	end

	always_ff @(posedge i_clk_sys) begin
		if (i_sys_rst) begin
			held_q <= FCW_DEFAULT;
		end else begin
			held_q <= held_d;
		end
	end

	// ----------------------------------------
	// process data
	// ----------------------------------------
	// on a Modbus link the qualifier only guards the command word, so data passes freely
	logic [PD_W-1:0]     pd_q;
	logic [PD_W-1:0]     pd_d;

	always_comb begin
		pd_d = (valid || i_is_modbus) ? i_proc_data : pd_q;
	end

	always_ff @(posedge i_clk_sys) begin
		if (i_sys_rst) begin
			pd_q <= PD_RESET;
		end else begin
			pd_q <= pd_d;
		end
	end

	// ----------------------------------------
	// effective word
	// ----------------------------------------
	// a watchdog fault wins over the held copy; the hold keeps updating underneath so the
	// last accepted word returns as soon as the fault clears
	logic [FCW_W-1:0]    eff_q;
	logic [FCW_W-1:0]    eff_d;

	always_comb begin
		eff_d            = i_wdog_fault ? FCW_DEFAULT : held_d;
		eff_d[BIT_WDOG]  = wd_live;
		eff_d[BIT_VALID] = valid;
	end

	always_ff @(posedge i_clk_sys) begin
		if (i_sys_rst) begin
			eff_q <= FCW_DEFAULT;
		end else begin
			eff_q <= eff_d;
		end
	end

	// ----------------------------------------
	// fault acknowledge edge
	// ----------------------------------------
	// the history follows the effective bit on every control place, so a level raised
	// off the fieldbus does not fire later when the fieldbus takes over
	logic                ack_ok;
	logic                ack_hist_q;
	logic                ack_hist_d;
	logic                ackp_q;
	logic                ackp_d;

	always_comb begin
		ack_ok     = i_place_fieldbus || i_ack_place_indep;
		ack_hist_d = eff_d[BIT_ACK];
		ackp_d     = eff_d[BIT_ACK] && !ack_hist_q && ack_ok;
	end

	always_ff @(posedge i_clk_sys) begin
		if (i_sys_rst) begin
			ack_hist_q <= 1'b0;
			ackp_q     <= 1'b0;
		end else begin
			ack_hist_q <= ack_hist_d;
			ackp_q     <= ackp_d;
		end
	end

	// ----------------------------------------
	// decoded commands
	// ----------------------------------------
	// reserved bits 5, 6, 8 and 9 have no decode and only ride along in the effective word
	logic [N_CUSTOM-1:0] cust_w;
	fcw_cmd_t            cmd_q;
	fcw_cmd_t            cmd_d;

	for (genvar gi = 0; gi < N_CUSTOM; gi++) begin : g_cust
		assign cust_w[gi] = eff_d[BIT_CUST_LO + gi];
	end

	always_comb begin
		cmd_d = '0;
		if (i_place_fieldbus) begin
			cmd_d.run_enable = eff_d[BIT_SW_ON_EN] && eff_d[BIT_START];
			cmd_d.quick_stop = !eff_d[BIT_QSTOP_N];
			cmd_d.mcb_enable = eff_d[BIT_MCB_EN];
			cmd_d.precharge  = eff_d[BIT_PRECHARGE];
			cmd_d.start      = eff_d[BIT_START];
			cmd_d.custom     = cust_w;
		end
	end

	always_ff @(posedge i_clk_sys) begin
		if (i_sys_rst) begin
			cmd_q <= '0;
		end else begin
			cmd_q <= cmd_d;
		end
	end

	// ----------------------------------------
	// watchdog to supervision
	// ----------------------------------------
	logic                wd_q;
	logic                wd_d;

	always_comb begin
		wd_d = wd_live;
	end

	always_ff @(posedge i_clk_sys) begin
		if (i_sys_rst) begin
			wd_q <= 1'b0;
		end else begin
			wd_q <= wd_d;
		end
	end

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	assign o_eff_word  = eff_q;
	assign o_proc_data = pd_q;
	assign o_cmd       = cmd_q;
	assign o_ack_pulse = ackp_q;
	assign o_wdog_in   = wd_q;

	// ----------------------------------------
	// checks
	// ----------------------------------------
	property p_ack_edge;
		@(posedge i_clk_sys) disable iff (i_sys_rst)
		o_ack_pulse |-> $past(ack_hist_d) && !$past(ack_hist_q);
	endproperty
	a_ack_edge: assert property (p_ack_edge) else $error("ack pulse without edge");

	property p_ack_single;
		@(posedge i_clk_sys) disable iff (i_sys_rst)
		o_ack_pulse |=> !o_ack_pulse;
	endproperty
	a_ack_single: assert property (p_ack_single) else $error("ack pulse too long");

	property p_hold;
		@(posedge i_clk_sys) disable iff (i_sys_rst)
		!i_cmd_word[BIT_VALID] |=> held_q == $past(held_q);
	endproperty
	a_hold: assert property (p_hold) else $error("held word changed while invalid");

	property p_take;
		@(posedge i_clk_sys) disable iff (i_sys_rst)
		i_cmd_word[BIT_VALID] |=> held_q == $past(i_cmd_word);
	endproperty
	a_take: assert property (p_take) else $error("valid word not taken");

	property p_modbus;
		@(posedge i_clk_sys) disable iff (i_sys_rst)
		i_is_modbus |=> o_proc_data == $past(i_proc_data);
	endproperty
	a_modbus: assert property (p_modbus) else $error("modbus data qualified");

	property p_wdog;
		@(posedge i_clk_sys) disable iff (i_sys_rst)
		1'b1 |=> o_eff_word[BIT_WDOG] == $past(i_cmd_word[BIT_WDOG]) && o_wdog_in == o_eff_word[BIT_WDOG];
	endproperty
	a_wdog: assert property (p_wdog) else $error("watchdog bit not live");

	property p_default;
		@(posedge i_clk_sys) disable iff (i_sys_rst)
		i_wdog_fault |=> (o_eff_word & 16'hF37F) == (FCW_DEFAULT & 16'hF37F);
	endproperty
	a_default: assert property (p_default) else $error("default word not forced");

	property p_place;
		@(posedge i_clk_sys) disable iff (i_sys_rst)
		!i_place_fieldbus |=> o_cmd == '0;
	endproperty
	a_place: assert property (p_place) else $error("command honoured off fieldbus");

	property p_custom;
		@(posedge i_clk_sys) disable iff (i_sys_rst)
		i_place_fieldbus |=> o_cmd.custom == o_eff_word[BIT_CUST_LO +: N_CUST];
	endproperty
	a_custom: assert property (p_custom) else $error("custom outputs wrong");

	property p_qstop;
		@(posedge i_clk_sys) disable iff (i_sys_rst)
		i_place_fieldbus |=> o_cmd.quick_stop == !o_eff_word[BIT_QSTOP_N]
		                  && o_cmd.run_enable == (o_eff_word[BIT_SW_ON_EN] && o_eff_word[BIT_START]);
	endproperty
	a_qstop: assert property (p_qstop) else $error("stop decode wrong");

	property p_ack_place;
		@(posedge i_clk_sys) disable iff (i_sys_rst)
		o_ack_pulse |-> $past(i_place_fieldbus) || $past(i_ack_place_indep);
	endproperty
	a_ack_place: assert property (p_ack_place) else $error("ack pulse from wrong place");

	property p_ack_fire;
		@(posedge i_clk_sys) disable iff (i_sys_rst)
		eff_d[BIT_ACK] && !ack_hist_q && i_place_fieldbus |=> o_ack_pulse;
	endproperty
	a_ack_fire: assert property (p_ack_fire) else $error("ack edge missed");

	property p_ack_hist;
		@(posedge i_clk_sys) disable iff (i_sys_rst)
		1'b1 |=> ack_hist_q == o_eff_word[BIT_ACK];
	endproperty
	a_ack_hist: assert property (p_ack_hist) else $error("ack history out of step");

	property p_reset_out;
		@(posedge i_clk_sys)
		i_sys_rst |=> o_eff_word == FCW_DEFAULT && o_cmd == '0 && !o_ack_pulse && !ack_hist_q;
	endproperty
	a_reset_out: assert property (p_reset_out) else $error("outputs not at reset values");

	property p_reset_pd;
		@(posedge i_clk_sys)
		i_sys_rst |=> o_proc_data == PD_RESET && held_q == FCW_DEFAULT && !o_wdog_in;
	endproperty
	a_reset_pd: assert property (p_reset_pd) else $error("held state not reset");

	property p_hold_pd;
		@(posedge i_clk_sys) disable iff (i_sys_rst)
		!i_cmd_word[BIT_VALID] && !i_is_modbus |=> o_proc_data == $past(o_proc_data);
	endproperty
	a_hold_pd: assert property (p_hold_pd) else $error("data changed while invalid");

	property p_take_pd;
		@(posedge i_clk_sys) disable iff (i_sys_rst)
		i_cmd_word[BIT_VALID] |=> o_proc_data == $past(i_proc_data);
	endproperty
	a_take_pd: assert property (p_take_pd) else $error("valid data not taken");

	property p_valid_live;
		@(posedge i_clk_sys) disable iff (i_sys_rst)
		1'b1 |=> o_eff_word[BIT_VALID] == $past(i_cmd_word[BIT_VALID]);
	endproperty
	a_valid_live: assert property (p_valid_live) else $error("qualifier bit not live");

	property p_eff_take;
		@(posedge i_clk_sys) disable iff (i_sys_rst)
		i_cmd_word[BIT_VALID] && !i_wdog_fault |=> o_eff_word == $past(i_cmd_word);
	endproperty
	a_eff_take: assert property (p_eff_take) else $error("effective word not taken");

	property p_eff_hold;
		@(posedge i_clk_sys) disable iff (i_sys_rst)
		!i_cmd_word[BIT_VALID] && !i_wdog_fault |=> (o_eff_word & 16'hF3FF) == ($past(held_q) & 16'hF3FF);
	endproperty
	a_eff_hold: assert property (p_eff_hold) else $error("effective word not held");

	property p_misc_cmd;
		@(posedge i_clk_sys) disable iff (i_sys_rst)
		i_place_fieldbus |=> o_cmd.start == o_eff_word[BIT_START] && o_cmd.mcb_enable == o_eff_word[BIT_MCB_EN]
		                  && o_cmd.precharge == o_eff_word[BIT_PRECHARGE];
	endproperty
	a_misc_cmd: assert property (p_misc_cmd) else $error("start decode wrong");

	property p_stop_clear;
		@(posedge i_clk_sys) disable iff (i_sys_rst)
		i_cmd_word[BIT_VALID] && !i_wdog_fault && !i_cmd_word[BIT_SW_ON_EN] |=> !o_cmd.run_enable;
	endproperty
	a_stop_clear: assert property (p_stop_clear) else $error("run kept without enable");

	property p_default_cmd;
		@(posedge i_clk_sys) disable iff (i_sys_rst)
		i_wdog_fault |=> o_cmd.custom == '0 && !o_cmd.run_enable && !o_cmd.quick_stop;
	endproperty
	a_default_cmd: assert property (p_default_cmd) else $error("default word not decoded");

	property p_wd_out;
		@(posedge i_clk_sys) disable iff (i_sys_rst)
		1'b1 |=> o_wdog_in == $past(i_cmd_word[BIT_WDOG]);
	endproperty
	a_wd_out: assert property (p_wd_out) else $error("watchdog tap stale");

endmodule

// *** tb/fcw_master.sv ***
// fieldbus master model: forwards the bench's command word, owns the watchdog bit
// assumes the bench changes i_word at the falling edge of i_clk_sys
module fcw_master
	import fcw_pkg::*;
(
	input  wire logic             i_clk_sys,
	input  wire logic [FCW_W-1:0] i_word,
	output logic [FCW_W-1:0]      o_cmd_word
);
	timeunit 1ns;
	timeprecision 1ps;
	logic wd_q = 1'b0;
	// heartbeat flips every cycle so a stale copy of bit 11 cannot pass
	always @(negedge i_clk_sys) wd_q <= ~wd_q;
	assign o_cmd_word = {i_word[15:12], wd_q, i_word[10:0]};
endmodule

// *** tb/tb_top.sv ***
// self-checking bench for the command word decoder
// assumes fcw_master supplies the word; inputs change at the falling edge
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import fcw_pkg::*;
	// ----------------------------------------
	// stimulus and wiring
	// ----------------------------------------
	logic        clk = 1'b0, rst = 1'b1, mb = 1'b0, pl = 1'b1, ind = 1'b0, wdf = 1'b0;
	logic [15:0] word = 16'h0000, pd = 16'h0000, cw, eff, pdo;
	fcw_cmd_t    cmd;
	logic        ack, wdo;
	// next values of the side inputs, applied by step at the falling edge
	logic [15:0] nxt_pd = 16'h0000;
	logic        nxt_mb = 1'b0, nxt_pl = 1'b1, nxt_ind = 1'b0, nxt_wdf = 1'b0;
	int          n_mismatch = 0;
	int          n_checks = 0;
	always #4 clk = ~clk;
	fcw_master mst (.i_clk_sys(clk), .i_word(word), .o_cmd_word(cw));
	fcw_decoder uut (.i_clk_sys(clk), .i_sys_rst(rst), .i_cmd_word(cw), .i_proc_data(pd), .i_is_modbus(mb),
		.i_place_fieldbus(pl), .i_ack_place_indep(ind), .i_wdog_fault(wdf), .o_eff_word(eff),
		.o_proc_data(pdo), .o_cmd(cmd), .o_ack_pulse(ack), .o_wdog_in(wdo));
	// ----------------------------------------
	// helpers
	// ----------------------------------------
	task automatic chk(string nm, logic [15:0] e, logic [15:0] g);
		n_checks++;
		if (g !== e) begin
			n_mismatch++;
			$display("ERROR %s expected %h seen %h", nm, e, g);
		end
	endtask
	// outputs are looked at 1 ns after the edge that took the word
	task automatic step(logic [15:0] w);
		@(negedge clk);
		word = w;
		pd   = nxt_pd;
		mb   = nxt_mb;
		pl   = nxt_pl;
		ind  = nxt_ind;
		wdf  = nxt_wdf;
		@(posedge clk);
		#1;
	endtask
	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic t_reset();
		chk("eff", 16'h0005, eff);
		chk("cmd", 16'h0000, cmd);
		chk("ack", 16'h0000, ack);
	endtask
	task automatic t_default();
		step(16'hF3C2);
		chk("eff", {4'h0, cw[11], 11'h005}, eff);
		chk("wdog", cw[11], wdo);
		chk("cmd", 16'h0000, cmd);
		chk("ack", 16'h0000, ack);
	endtask
	task automatic t_accept();
		nxt_pd = 16'h1234;
		step(16'h1789);
		chk("eff", {4'h1, cw[11], 11'h789}, eff);
		chk("pd", 16'h1234, pdo);
		chk("cmd", 16'h0191, cmd);
		chk("cust", 16'h0001, cmd.custom);
		chk("run", 16'h0001, cmd.run_enable);
		chk("qstop", 16'h0001, cmd.quick_stop);
		chk("ack", 16'h0001, ack);
		step(16'h1789);
		chk("ack", 16'h0000, ack);
		nxt_pd = 16'h5555;
		step(16'h0004);
		chk("eff", {4'h1, cw[11], 11'h389}, eff);
		chk("pd", 16'h1234, pdo);
		nxt_mb = 1'b1;
		step(16'h0004);
		chk("pd", 16'h5555, pdo);
		chk("eff", {4'h1, cw[11], 11'h389}, eff);
		nxt_mb = 1'b0;
	endtask
	task automatic t_place();
		step(16'h0412);
		chk("cmd", 16'h00E0, cmd);
		nxt_pl = 1'b0;
		step(16'h1480);
		chk("cmd", 16'h0000, cmd);
		chk("ack", 16'h0000, ack);
		step(16'h0400);
		nxt_ind = 1'b1;
		step(16'h0480);
		chk("ack", 16'h0001, ack);
		nxt_pl = 1'b1;
		nxt_ind = 1'b0;
	endtask
	task automatic t_wdfault();
		nxt_wdf = 1'b1;
		step(16'h1480);
		chk("eff", {4'h0, cw[11], 11'h405}, eff);
		chk("cust", 16'h0000, cmd.custom);
		chk("ack", 16'h0000, ack);
		nxt_wdf = 1'b0;
	endtask
	// a held acknowledge level must fire again once reset has wiped the history
	task automatic t_midreset();
		step(16'h0480);
		chk("ack", 16'h0001, ack);
		step(16'h0480);
		chk("ack", 16'h0000, ack);
		@(negedge clk);
		rst = 1'b1;
		@(negedge clk);
		chk("eff", 16'h0005, eff);
		chk("ack", 16'h0000, ack);
		rst = 1'b0;
		@(posedge clk);
		#1;
		chk("ack", 16'h0001, ack);
	endtask
	task automatic finish_test();
		$display("checks %0d mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	initial begin
		#20000;
		n_mismatch++;
		finish_test();
	end
	initial begin
		repeat (5) @(negedge clk);
		t_reset();
		rst = 1'b0;
		t_default();
		t_accept();
		t_place();
		t_wdfault();
		t_midreset();
		finish_test();
	end
endmodule
